/* File: logic/lcd_params.svh */
// register indices, field positions, reset values and selector codes of the channel divider pair
`ifndef LCD_PARAMS_SVH
`define LCD_PARAMS_SVH

// ******************************************
// register indices (byte address = 4 * index)
// ******************************************
`define LCD_IDX_W        10
`define LCD_IDX_B_COUNTS 10'h193
`define LCD_IDX_B_CTRL   10'h194
`define LCD_IDX_B_ROUTE  10'h195
`define LCD_IDX_C_COUNTS 10'h196
`define LCD_IDX_C_CTRL   10'h197
`define LCD_IDX_C_ROUTE  10'h198
`define LCD_IDX_STATUS   10'h1F0

// ******************************************
// reset values
// ******************************************
`define LCD_RST_COUNTS   8'h00
`define LCD_RST_CTRL     8'h80
`define LCD_RST_ROUTE    8'h00

// ******************************************
// field positions
// ******************************************
`define LCD_LOW_HI       7
`define LCD_LOW_LO       4
`define LCD_HIGH_HI      3
`define LCD_HIGH_LO      0
`define LCD_BIT_BYPASS   7
`define LCD_BIT_NOSYNC   6
`define LCD_BIT_FORCE    5
`define LCD_BIT_START    4
`define LCD_PHASE_HI     3
`define LCD_PHASE_LO     0
`define LCD_BIT_DIRECT   1
`define LCD_BIT_DCC_OFF  0

// ******************************************
// distribution source select codes
// ******************************************
`define LCD_SRC_EXT      2'h0
`define LCD_SRC_OSC      2'h2

`endif

/* File: logic/lcd_pkg.sv */
// types shared by the channel divider pair
package lcd_pkg;

  typedef struct packed {
    logic [3:0] low_cycles;
    logic [3:0] high_cycles;
    logic       bypass;
    logic       nosync;
    logic       force_high;
    logic       start_high;
    logic [3:0] phase_offset;
    logic       duty_correction_disable;
  } lcd_div_cfg_t;

  typedef enum logic [1:0] {
    LCD_HOLD,
    LCD_DELAY,
    LCD_RUN
  } lcd_div_state_t;

  typedef struct packed {
    lcd_div_state_t st;
    logic [4:0]     cnt;
    logic           level;
    logic           clk_prev;
    logic           out;
  } lcd_div_q_t;

  typedef struct packed {
    logic p;
    logic n;
  } lcd_pair_t;

  typedef struct packed {
    logic [7:0]  b_counts;
    logic [7:0]  b_ctrl;
    logic [7:0]  b_route;
    logic [7:0]  c_counts;
    logic [7:0]  c_ctrl;
    logic [7:0]  c_route;
    logic        waitreq;
    logic [31:0] rdata;
  } lcd_top_q_t;

endpackage

/* File: logic/lcd_divider.sv */
// one channel divider: counted low/high phases, bypass, force, start level, phase offset, duty correction
`timescale 1ns/1ns
`include "lcd_params.svh"
module lcd_divider (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // configuration
  input  wire lcd_pkg::lcd_div_cfg_t cfg,
  // divider input clock level and chip-level sync
  input  wire logic                  clk_in,
  input  wire logic                  sync_in,
  // divided output
  output logic                       div_out
);
  import lcd_pkg::*;

  lcd_div_q_t q_q;
  lcd_div_q_t q_d;
  logic       edge_in;
  logic [4:0] low_len;
  logic [4:0] high_len;
  logic [5:0] total_len;
  logic [4:0] dcc_high;
  logic [4:0] dcc_low;
  logic [4:0] cur_len;

  always_comb begin
    low_len   = {1'b0, cfg.low_cycles} + 5'h01;   // R1
    high_len  = {1'b0, cfg.high_cycles} + 5'h01;  // R2
    total_len = {1'b0, low_len} + {1'b0, high_len};
    // duty correction keeps the period but splits it evenly, odd cycle goes to high
    dcc_high  = 5'((total_len + 6'h01) >> 1);
    dcc_low   = 5'(total_len - {1'b0, dcc_high});
    if (cfg.duty_correction_disable) begin  // R12
      cur_len = q_q.level ? high_len : low_len;
    end else begin
      cur_len = q_q.level ? dcc_high : dcc_low;
    end
  end

  always_comb begin
    q_d          = q_q;
    edge_in      = clk_in & ~q_q.clk_prev;
    q_d.clk_prev = clk_in;
    if (cfg.bypass) begin
      // counter parked so it restarts cleanly when bypass drops
      q_d.st  = LCD_HOLD;  // R3
      q_d.cnt = 5'h00;
      q_d.out = clk_in;    // R3
    end else if (cfg.nosync && cfg.force_high) begin
      q_d.out = 1'b1;      // R5
    end else if (sync_in && !cfg.nosync) begin
      q_d.st    = LCD_HOLD;  // R4
      q_d.cnt   = 5'h00;
      q_d.level = cfg.start_high;  // R6
      q_d.out   = cfg.start_high;  // R14
    end else begin
      case (q_q.st)
        LCD_HOLD: begin
          q_d.cnt   = 5'h00;
          q_d.level = cfg.start_high;  // R6
          if (cfg.phase_offset == 4'h0) begin
            q_d.st = LCD_RUN;
          end else begin
            q_d.st = LCD_DELAY;
          end
        end
        LCD_DELAY: begin
          if (edge_in) begin
            if (q_q.cnt == {1'b0, cfg.phase_offset} - 5'h01) begin  // R7 R14
              q_d.st  = LCD_RUN;
              q_d.cnt = 5'h00;
            end else begin
              q_d.cnt = q_q.cnt + 5'h01;
            end
          end
        end
        LCD_RUN: begin
          if (edge_in) begin
            if (q_q.cnt >= cur_len - 5'h01) begin  // R13
              q_d.level = ~q_q.level;
              q_d.cnt   = 5'h00;
            end else begin
              q_d.cnt = q_q.cnt + 5'h01;
            end
          end
        end
        default: begin
          q_d.st = LCD_HOLD;
        end
      endcase
      q_d.out = q_d.level;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_q <= '{st: LCD_HOLD, cnt: 5'h00, level: 1'b0, clk_prev: 1'b0, out: 1'b0};
    end else begin
      q_q <= q_d;
    end
  end

  assign div_out = q_q.out;
endmodule

/* File: logic/lcd_route.sv */
// output pair mux: divider or direct oscillator / external clock, driven differentially
`timescale 1ns/1ns
`include "lcd_params.svh"
module lcd_route (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // selection
  input  wire logic       direct_route,
  input  wire logic [1:0] src_sel,
  // candidate sources
  input  wire logic       div_in,
  input  wire logic       osc_in,
  input  wire logic       ext_in,
  // differential pair
  output logic            out_p,
  output logic            out_n
);
  import lcd_pkg::*;

  lcd_pair_t q_q;
  lcd_pair_t q_d;
  logic      pick;

  always_comb begin
    pick = div_in;  // R8 R11
    if (direct_route && src_sel == `LCD_SRC_OSC) begin
      pick = osc_in;  // R9
    end else if (direct_route && src_sel == `LCD_SRC_EXT) begin
      pick = ext_in;  // R10
    end
    q_d.p = pick;
    q_d.n = ~pick;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_q <= '{p: 1'b0, n: 1'b1};
    end else begin
      q_q <= q_d;
    end
  end

  assign out_p = q_q.p;
  assign out_n = q_q.n;
endmodule

/* File: logic/lcd_top.sv */
// channel divider pair top: Avalon-MM registers, two dividers and two output pair routes
//
// Function
// R1 - output low for low-count plus one input cycles.
// R2 - output high for high-count plus one input cycles; field resets zero.
// R3 - bypass bit stops divider and passes input clock to output.
// R4 - divider follows sync unless sync-ignore bit is set.
// R5 - force-level needs sync-ignore; then force bit one drives output high.
// R6 - divided clock starts at level chosen by start-polarity bit, default low.
// R7 - four-bit phase-offset field, reset zero, sets coarse starting phase.
// R8 - direct-route zero: pair b from second divider, pair c from third.
// R9 - direct-route one and select 10b: oscillator goes straight to pair.
// R10 - direct-route one and select 00b: external clock goes straight to pair.
// R11 - select 01b ignores direct-route; pair stays on divider.
// R12 - duty correction on while disable bit zero, off when one.
// R13 - period is low plus high lengths, repeating while dividing.
// R14 - sync restarts non-ignoring divider at start level after phase offset.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ns
`include "lcd_params.svh"
module lcd_top (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // clock sources and chip-level sync
  input  wire logic        dist_clk_in,
  input  wire logic        osc_clk_in,
  input  wire logic        ext_clk_in,
  input  wire logic [1:0]  dist_src_sel,
  input  wire logic        sync_in,
  // output pairs
  output logic             pair_b_out_p,
  output logic             pair_b_out_n,
  output logic             pair_c_out_p,
  output logic             pair_c_out_n
);
  import lcd_pkg::*;

  lcd_top_q_t              q_q;
  lcd_top_q_t              q_d;
  lcd_div_cfg_t            cfg_b;
  lcd_div_cfg_t            cfg_c;
  logic                    div_b;
  logic                    div_c;
  logic [`LCD_IDX_W-1:0]   idx;
  logic                    req;
  logic                    wr_go;
  logic [7:0]              wbyte;

  // ******************************************
  // configuration unpacking
  // ******************************************
  function automatic lcd_div_cfg_t unpack_cfg(input logic [7:0] counts,
                                              input logic [7:0] ctrl,
                                              input logic [7:0] route);
    lcd_div_cfg_t c;
    c.low_cycles              = counts[`LCD_LOW_HI:`LCD_LOW_LO];    // R1
    c.high_cycles             = counts[`LCD_HIGH_HI:`LCD_HIGH_LO];  // R2
    c.bypass                  = ctrl[`LCD_BIT_BYPASS];              // R3
    c.nosync                  = ctrl[`LCD_BIT_NOSYNC];              // R4
    c.force_high              = ctrl[`LCD_BIT_FORCE];               // R5
    c.start_high              = ctrl[`LCD_BIT_START];               // R6
    c.phase_offset            = ctrl[`LCD_PHASE_HI:`LCD_PHASE_LO];  // R7
    c.duty_correction_disable = route[`LCD_BIT_DCC_OFF];            // R12
    return c;
  endfunction

  always_comb begin
    cfg_b = unpack_cfg(q_q.b_counts, q_q.b_ctrl, q_q.b_route);
    cfg_c = unpack_cfg(q_q.c_counts, q_q.c_ctrl, q_q.c_route);
  end

  // ******************************************
  // register bus
  // ******************************************
  // every access takes exactly one wait cycle; read data is captured on the edge that drops
  // waitrequest and the write lands on the next edge, so decode and readback never race.
  always_comb begin
    q_d   = q_q;
    idx   = avs_address[11:2];
    req   = avs_read | avs_write;
    wr_go = avs_write & ~q_q.waitreq & avs_byteenable[0];
    wbyte = avs_writedata[7:0];
    if (req && q_q.waitreq) begin
      q_d.waitreq = 1'b0;
      q_d.rdata   = 32'h00000000;
      case (idx)
        `LCD_IDX_B_COUNTS: q_d.rdata[7:0] = q_q.b_counts;
        `LCD_IDX_B_CTRL:   q_d.rdata[7:0] = q_q.b_ctrl;
        `LCD_IDX_B_ROUTE:  q_d.rdata[7:0] = q_q.b_route;
        `LCD_IDX_C_COUNTS: q_d.rdata[7:0] = q_q.c_counts;
        `LCD_IDX_C_CTRL:   q_d.rdata[7:0] = q_q.c_ctrl;
        `LCD_IDX_C_ROUTE:  q_d.rdata[7:0] = q_q.c_route;
        `LCD_IDX_STATUS:   q_d.rdata[3:0] = {pair_c_out_n, pair_c_out_p, pair_b_out_n, pair_b_out_p};
        default:           q_d.rdata = 32'h00000000;
      endcase
    end else begin
      q_d.waitreq = 1'b1;
    end
    if (wr_go) begin
      case (idx)
        `LCD_IDX_B_COUNTS: q_d.b_counts = wbyte;
        `LCD_IDX_B_CTRL:   q_d.b_ctrl   = wbyte;
        // only the direct and correction bits exist in the route registers
        `LCD_IDX_B_ROUTE:  q_d.b_route  = {6'h00, wbyte[`LCD_BIT_DIRECT], wbyte[`LCD_BIT_DCC_OFF]};
        `LCD_IDX_C_COUNTS: q_d.c_counts = wbyte;
        `LCD_IDX_C_CTRL:   q_d.c_ctrl   = wbyte;
        `LCD_IDX_C_ROUTE:  q_d.c_route  = {6'h00, wbyte[`LCD_BIT_DIRECT], wbyte[`LCD_BIT_DCC_OFF]};
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_q.b_counts <= `LCD_RST_COUNTS;
      q_q.b_ctrl   <= `LCD_RST_CTRL;
      q_q.b_route  <= `LCD_RST_ROUTE;
      q_q.c_counts <= `LCD_RST_COUNTS;
      q_q.c_ctrl   <= `LCD_RST_CTRL;
      q_q.c_route  <= `LCD_RST_ROUTE;
      q_q.waitreq  <= 1'b1;
      q_q.rdata    <= 32'h00000000;
    end else begin
      q_q <= q_d;
    end
  end

  assign avs_readdata    = q_q.rdata;
  assign avs_waitrequest = q_q.waitreq;

  // ******************************************
  // dividers and output pairs
  // ******************************************
  lcd_divider u_div_b (
    .clock   (clock),
    .rst     (rst),
    .cfg     (cfg_b),
    .clk_in  (dist_clk_in),
    .sync_in (sync_in),
    .div_out (div_b)
  );

  lcd_divider u_div_c (
    .clock   (clock),
    .rst     (rst),
    .cfg     (cfg_c),
    .clk_in  (dist_clk_in),
    .sync_in (sync_in),
    .div_out (div_c)
  );

  lcd_route u_route_b (
    .clock        (clock),
    .rst          (rst),
    .direct_route (q_q.b_route[`LCD_BIT_DIRECT]),  // R8
    .src_sel      (dist_src_sel),
    .div_in       (div_b),
    .osc_in       (osc_clk_in),
    .ext_in       (ext_clk_in),
    .out_p        (pair_b_out_p),
    .out_n        (pair_b_out_n)
  );

  lcd_route u_route_c (
    .clock        (clock),
    .rst          (rst),
    .direct_route (q_q.c_route[`LCD_BIT_DIRECT]),  // R8
    .src_sel      (dist_src_sel),
    .div_in       (div_c),
    .osc_in       (osc_clk_in),
    .ext_in       (ext_clk_in),
    .out_p        (pair_c_out_p),
    .out_n        (pair_c_out_n)
  );
endmodule

/* File: sim/lcd_properties.sv */
// port checker of the channel divider pair
`timescale 1ns/1ns
module lcd_properties (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // register bus
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // sources and sync
  input wire logic        dist_clk_in,
  input wire logic        osc_clk_in,
  input wire logic        ext_clk_in,
  input wire logic [1:0]  dist_src_sel,
  input wire logic        sync_in,
  // output pairs
  input wire logic        pair_b_out_p,
  input wire logic        pair_b_out_n,
  input wire logic        pair_c_out_p,
  input wire logic        pair_c_out_n
);
  // ****
  // shadow of pair b configuration
  // ****
  logic [7:0] ctl_q;
  logic       dir_q;
  logic [1:0] sel_q;
  logic [2:0] quiet_q;
  wire        wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  // settled config: divider and route flops need a few edges after any change
  wire        ok = quiet_q >= 3'h4;
  wire        dv = !(dir_q && !dist_src_sel[0]);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_q <= 8'h80;
      dir_q <= 1'h0;
      sel_q <= 2'h0;
      quiet_q <= 3'h0;
    end else begin
      if (wr_ok && avs_address[11:2] == 10'h194) ctl_q <= avs_writedata[7:0];
      if (wr_ok && avs_address[11:2] == 10'h195) dir_q <= avs_writedata[1];
      sel_q <= dist_src_sel;
      if (wr_ok || sel_q != dist_src_sel) quiet_q <= 3'h0;
      else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
    end
  end
  // ****
  // assertions
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_b_pair_diff: assert property (pair_b_out_n == !pair_b_out_p)
    else $error("pair b not differential");
  chk_c_pair_diff: assert property (pair_c_out_n == !pair_c_out_p)
    else $error("pair c not differential");
  chk_bypass_follow: assert property (ok && ctl_q[7] && dv && $past(dist_clk_in) == $past(dist_clk_in, 2)
    |-> pair_b_out_p == $past(dist_clk_in)) else $error("bypass does not pass input clock");
  chk_osc_direct: assert property (ok && dir_q && dist_src_sel == 2'h2
    && $past(osc_clk_in) == $past(osc_clk_in, 2) |-> pair_b_out_p == $past(osc_clk_in))
    else $error("oscillator not routed");
  chk_ext_direct: assert property (ok && dir_q && dist_src_sel == 2'h0
    && $past(ext_clk_in) == $past(ext_clk_in, 2) |-> pair_b_out_p == $past(ext_clk_in))
    else $error("external clock not routed");
  chk_sel_ignore: assert property (ok && dir_q && dist_src_sel == 2'h1 && ctl_q[7:5] == 3'h3
    |-> pair_b_out_p) else $error("direct route not ignored");
  chk_force_high: assert property (ok && dv && ctl_q[7:5] == 3'h3 |-> pair_b_out_p)
    else $error("forced level missing");
  chk_sync_hold: assert property (sync_in [*3] ##0 (ok && dv && ctl_q[7:6] == 2'h0)
    |-> pair_b_out_p == ctl_q[4]) else $error("sync does not hold start level");
endmodule
bind lcd_top lcd_properties i_chk (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .dist_clk_in, .osc_clk_in, .ext_clk_in,
  .dist_src_sel, .sync_in, .pair_b_out_p, .pair_b_out_n, .pair_c_out_p, .pair_c_out_n);

/* File: sim/tb.sv */
// self-checking bench of the channel divider pair
`timescale 1ns/1ns
module tb;
  logic        clock = 1'h0;
  logic        rst = 1'h1;
  logic [11:0] adr = 12'h0;
  logic        rd = 1'h0;
  logic        wr = 1'h0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'h0;
  logic [1:0]  dcnt = 2'h0;
  logic [1:0]  sel = 2'h0;
  logic        osc = 1'h0;
  logic        ext = 1'h0;
  logic        sync = 1'h0;
  logic [31:0] rdat;
  logic        wrq, bp, bn, cp, cn;
  int          bad_count = 0;
  int          checked = 0;
  logic [11:0] ra [6] = '{12'h64C, 12'h650, 12'h654, 12'h658, 12'h65C, 12'h660};
  logic [7:0]  rv [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00};
  // counts, route, high cycles, low cycles (divider input is a quarter of clock)
  logic [31:0] pt [5] = '{32'h00010404, 32'h2501180C, 32'hFF014040, 32'h4100100C, 32'h02000808};
  // direct, select, oscillator, external, expected pair level
  logic [5:0]  rt [6] = '{6'h32, 6'h35, 6'h24, 6'h23, 6'h29, 6'h11};
  always #25 clock = ~clock;
  always @(posedge clock) dcnt <= dcnt + 2'h1;
  lcd_top i_dut (.clock(clock), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wrq),
    .dist_clk_in(dcnt[1]), .osc_clk_in(osc), .ext_clk_in(ext), .dist_src_sel(sel), .sync_in(sync),
    .pair_b_out_p(bp), .pair_b_out_n(bn), .pair_c_out_p(cp), .pair_c_out_n(cn));
  // ****
  // tasks
  // ****
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] b,
                     output logic [31:0] r);
    int i;
    @(posedge clock);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {24'h0, d};
    be <= b;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (wrq === 1'h0) break;
    end
    if (i == 20) begin
      bad_count++;
      complete_run();
    end
    r = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  task automatic wrt(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    acc(1'h1, a, d, 4'hF, r);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] r;
    acc(1'h0, a, 8'h00, 4'hF, r);
    check(r, {24'h0, e});
  endtask
  task automatic run_len(input logic v, output int n);
    n = 0;
    while (bp === v && n < 300) begin
      @(posedge clock);
      n++;
    end
    // a level that never ends means a stuck divider: count it and close the run
    if (n == 300) begin
      bad_count++;
      complete_run();
    end
  endtask
  // sync release lands at a fixed phase of the divider input so lengths compare exactly
  task automatic resync;
    int i;
    sync <= 1'h1;
    repeat (8) @(posedge clock);
    for (i = 0; i < 4 && dcnt !== 2'h3; i++) @(posedge clock);
    sync <= 1'h0;
  endtask
  // ****
  // tests
  // ****
  initial begin
    logic [31:0] r;
    int n, t0, k, j;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    for (k = 0; k < 6; k++) rchk(ra[k], rv[k]);
    wrt(12'h650, 8'h5A);
    rchk(12'h650, 8'h5A);
    wrt(12'h654, 8'hFF);
    rchk(12'h654, 8'h03);
    acc(1'h1, 12'h64C, 8'h33, 4'h0, r);
    rchk(12'h64C, 8'h00);
    wrt(12'h100, 8'h77);
    rchk(12'h100, 8'h00);
    $display("test registers done");
    wrt(12'h650, 8'h00);
    for (k = 0; k < 5; k++) begin
      wrt(12'h64C, pt[k][31:24]);
      wrt(12'h654, pt[k][23:16]);
      resync();
      run_len(1'h0, n);
      run_len(1'h1, n);
      run_len(1'h0, n);
      check(n, pt[k][7:0]);
      run_len(1'h1, n);
      check(n, pt[k][15:8]);
    end
    $display("test ratios done");
    wrt(12'h64C, 8'h00);
    wrt(12'h654, 8'h01);
    for (k = 0; k < 4; k++) begin
      wrt(12'h650, {3'h0, k[1], 2'h0, k[0], k[0]});
      resync();
      check(bp, k[1]);
      run_len(k[1], n);
      if (!k[0]) t0 = n;
      else check(n - t0, 12);
    end
    $display("test phase done");
    sync <= 1'h1;
    wrt(12'h650, 8'h40);
    repeat (8) @(posedge clock);
    run_len(bp, n);
    check(n < 8, 1'h1);
    wrt(12'h650, 8'h20);
    repeat (8) @(posedge clock);
    check(bp, 1'h0);
    wrt(12'h650, 8'h60);
    repeat (8) @(posedge clock);
    check(bp, 1'h1);
    sync <= 1'h0;
    $display("test force done");
    for (k = 0; k < 2; k++) begin
      wrt(k ? 12'h65C : 12'h650, 8'h60);
      for (j = 0; j < 6; j++) begin
        wrt(k ? 12'h660 : 12'h654, {6'h0, rt[j][5], 1'h0});
        sel <= rt[j][4:3];
        osc <= rt[j][2];
        ext <= rt[j][1];
        repeat (6) @(posedge clock);
        check(k ? cp : bp, rt[j][0]);
        check(k ? cn : bn, !rt[j][0]);
      end
    end
    rchk(12'h7C0, 8'h05);
    $display("test routing done");
    complete_run();
  end
endmodule
